// ---- rtl/spr_top.sv ----
// start-pattern recognizer with receive/transmit config registers
// assumes apb master on mclk; rxBit/rxBitValid come from same clock
`timescale 1ns/100ps
`default_nettype none
`include "spr_consts.svh"
module spr_top
(
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rst,
    // apb
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // demodulated data and recovery
    input  wire logic              rxRaw,
    input  wire logic              rxRawValid,
    input  wire logic              rxBit,
    input  wire logic              rxBitValid,
    input  wire spr_pkg::spr_byte_t rssiIn,
    // configuration to analogue and recovery
    output logic                   recoveryEnable,
    output logic                   polyphaseEnable,
    output spr_pkg::spr_byte_t     onoffThreshold,
    output logic [2:0]             peakDecayStep,
    output logic [2:0]             peakUpdateRate,
    output logic [1:0]             averageFilterSelect,
    output logic [3:0]             transmitFilterIndex,
    output logic [2:0]             outputPower,
    // recognizer result
    output logic                   patternFound
);
    import spr_pkg::*;

    spr_byte_t  ctrl_reg, ctrl_next;
    spr_byte_t  thr_reg, thr_next;
    spr_byte_t  peak_reg, peak_next;
    spr_byte_t  tx_reg, tx_next;
    spr_byte_t  pat_reg [4];
    spr_byte_t  pat_next [4];
    spr_byte_t  rssi_reg, rssi_next;
    logic [31:0] hist_reg, hist_next;
    logic [5:0]  fill_reg, fill_next;
    logic        found_reg, found_next;
    logic        sticky_reg, sticky_next;
    spr_state_t  state_reg, state_next;
    logic        wrStb, rdOk;
    logic [7:0]  wrIdx;
    logic [5:0]  errCnt;
    logic [31:0] patWord, care;
    logic [5:0]  need;
    logic        useBit, useValid;

    spr_apb_slave u_apb
    (
        .mclk    (mclk),
        .rst     (rst),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pready  (pready),
        .pslverr (pslverr),
        .wrStb   (wrStb),
        .wrIdx   (wrIdx),
        .rdOk    (rdOk)
    );

    // register writes
    always_comb
    begin
        ctrl_next = ctrl_reg;
        thr_next  = thr_reg;
        peak_next = peak_reg;
        tx_next   = tx_reg;
        for (int i = 0; i < 4; i++)
        begin
            pat_next[i] = pat_reg[i];
        end
        if (wrStb)
        begin
            unique case (wrIdx)
                `SPR_OFF_CTRL:   ctrl_next = pwdata[7:0] & `SPR_MASK_CTRL;
                `SPR_OFF_THRESH: thr_next = pwdata[7:0];
                `SPR_OFF_PEAK:   peak_next = pwdata[7:0];
                `SPR_OFF_PAT0:   pat_next[0] = pwdata[7:0];
                `SPR_OFF_PAT1:   pat_next[1] = pwdata[7:0];
                `SPR_OFF_PAT2:   pat_next[2] = pwdata[7:0];
                `SPR_OFF_PAT3:   pat_next[3] = pwdata[7:0];
                `SPR_OFF_TX:     tx_next = pwdata[7:0] & `SPR_MASK_TX;
                default:         ctrl_next = ctrl_reg;
            endcase
        end
    end

    // read mux; strength shows live state, the match flag is sticky
    always_comb
    begin
        prdata = 32'h0000_0000;
        if (rdOk)
        begin
            unique case (paddr[9:2])
                `SPR_OFF_CTRL:   prdata[7:0] = ctrl_reg;
                `SPR_OFF_THRESH: prdata[7:0] = thr_reg;
                `SPR_OFF_RSSI:   prdata[7:0] = rssi_reg;
                `SPR_OFF_PEAK:   prdata[7:0] = peak_reg;
                `SPR_OFF_PAT0:   prdata[7:0] = pat_reg[0];
                `SPR_OFF_PAT1:   prdata[7:0] = pat_reg[1];
                `SPR_OFF_PAT2:   prdata[7:0] = pat_reg[2];
                `SPR_OFF_PAT3:   prdata[7:0] = pat_reg[3];
                `SPR_OFF_TX:     prdata[7:0] = tx_reg;
                `SPR_OFF_STAT:   prdata[0] = sticky_reg;
                default:         prdata = 32'h0000_0000;
            endcase
        end
    end

    assign useBit   = ctrl_reg[`SPR_BIT_RECDIS] ? rxRaw : rxBit;
    assign useValid = ctrl_reg[`SPR_BIT_RECDIS] ? rxRawValid : rxBitValid;

    always_comb
    begin
        need = {1'b0, ctrl_reg[`SPR_BIT_SZHI:`SPR_BIT_SZLO], 3'b000} + 6'd8;
        // first byte most significant, aligned to oldest bit
        patWord = {pat_reg[0], pat_reg[1], pat_reg[2], pat_reg[3]};
        unique case (ctrl_reg[`SPR_BIT_SZHI:`SPR_BIT_SZLO])
            2'b00:
            begin
                patWord = {24'h00_0000, pat_reg[0]};
                care    = 32'h0000_00ff;
            end
            2'b01:
            begin
                patWord = {16'h0000, pat_reg[0], pat_reg[1]};
                care    = 32'h0000_ffff;
            end
            2'b10:
            begin
                patWord = {8'h00, pat_reg[0], pat_reg[1], pat_reg[2]};
                care    = 32'h00ff_ffff;
            end
            default: care = 32'hffff_ffff;
        endcase
    end

    spr_match u_match
    (
        .hist   (hist_reg),
        .pat    (patWord),
        .care   (care),
        .errCnt (errCnt)
    );

    // recognizer
    always_comb
    begin
        state_next  = state_reg;
        hist_next   = hist_reg;
        fill_next   = fill_reg;
        found_next  = 1'b0;
        rssi_next   = rssiIn;
        unique case (state_reg)
            SPR_ST_IDLE:
            begin
                fill_next = 6'd0;
                if (ctrl_reg[`SPR_BIT_RECOG])
                begin
                    state_next = SPR_ST_HUNT;
                end
            end
            SPR_ST_HUNT:
            begin
                if (!ctrl_reg[`SPR_BIT_RECOG])
                begin
                    state_next = SPR_ST_IDLE;
                end
                else if (useValid)
                begin
                    hist_next = {hist_reg[30:0], useBit};
                    if (fill_reg != 6'd32)
                    begin
                        fill_next = fill_reg + 6'd1;
                    end
                end
            end
            // illegal one-hot codes fall back to idle
            default:
            begin
                state_next = SPR_ST_IDLE;
                fill_next  = 6'd0;
            end
        endcase
        // accept up to tolerance code errors
        if (state_reg == SPR_ST_HUNT && fill_reg >= need
            && errCnt <= {4'h0, ctrl_reg[`SPR_BIT_TOLHI:`SPR_BIT_TOLLO]}
            && ctrl_reg[`SPR_BIT_RECOG])
        begin
            found_next = 1'b1;
        end
    end

    // status flag: write 1 clears, a match in the same cycle wins
    always_comb
    begin
        sticky_next = sticky_reg;
        if (wrStb && wrIdx == `SPR_OFF_STAT && pwdata[0])
        begin
            sticky_next = 1'b0;
        end
        if (found_next)
        begin
            sticky_next = 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            sticky_reg <= 1'b0;
        end
        else
        begin
            sticky_reg <= sticky_next;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ctrl_reg   <= `SPR_RST_CTRL;
            thr_reg    <= `SPR_RST_THRESH;
            peak_reg   <= `SPR_RST_PEAK;
            tx_reg     <= `SPR_RST_TX;
            rssi_reg   <= 8'h00;
            hist_reg   <= 32'h0000_0000;
            fill_reg   <= 6'd0;
            found_reg  <= 1'b0;
            state_reg  <= SPR_ST_IDLE;
        end
        else
        begin
            ctrl_reg   <= ctrl_next;
            thr_reg    <= thr_next;
            peak_reg   <= peak_next;
            tx_reg     <= tx_next;
            rssi_reg   <= rssi_next;
            hist_reg   <= hist_next;
            fill_reg   <= fill_next;
            found_reg  <= found_next;
            state_reg  <= state_next;
        end
    end

    // one storage slot per pattern byte
    for (genvar g = 0; g < 4; g++)
    begin : g_pat
        always_ff @(posedge mclk)
        begin
            if (rst)
            begin
                pat_reg[g] <= `SPR_RST_PAT;
            end
            else
            begin
                pat_reg[g] <= pat_next[g];
            end
        end
    end

    // configuration outputs straight from registers
    // recovery enable out
    assign recoveryEnable      = !ctrl_reg[`SPR_BIT_RECDIS];
    assign polyphaseEnable     = ctrl_reg[7];
    assign onoffThreshold      = thr_reg;
    assign peakDecayStep       = peak_reg[7:5];
    assign peakUpdateRate      = peak_reg[4:2];
    assign averageFilterSelect = peak_reg[1:0];
    assign transmitFilterIndex = tx_reg[7:4];
    assign outputPower         = tx_reg[3:1];
    assign patternFound        = found_reg;
endmodule : spr_top
`default_nettype wire

// ---- rtl/spr_consts.svh ----
// constants for the start-pattern recognizer and receive config block
// assumes inclusion by files that need offsets, fields and reset values
// Notes on behaviour
// - recovery_disable bit 6 zero runs data/clock recovery, one bypasses it.
// - pattern search happens only while recognition enable bit 5 is set.
// - pattern_size bits 4,3 select one to four pattern bytes, first byte always.
// - tolerance bits 2,1 allow zero to three bit mismatches.
// - pattern bytes 0x16 to 0x19, first most significant and sent first.
// - onoff_threshold eight bits, 0.5 dB per count, reset 6 dB.
// - peak_decay_step bits 7..5 choose decay of tracked maximum level.
// - peak_update_rate bits 4..2 choose update period or multiple per chip.
// - average_filter_select bits 1,0 choose averaging cutoff.
// - transmit_filter_index bits 7..4, reset 0111.
// - output power bits 3..1, 000 strongest, 111 weakest.
`ifndef SPR_CONSTS_SVH
`define SPR_CONSTS_SVH
`define SPR_OFF_CTRL      8'h12
`define SPR_OFF_THRESH    8'h13
`define SPR_OFF_RSSI      8'h14
`define SPR_OFF_PEAK      8'h15
`define SPR_OFF_PAT0      8'h16
`define SPR_OFF_PAT1      8'h17
`define SPR_OFF_PAT2      8'h18
`define SPR_OFF_PAT3      8'h19
`define SPR_OFF_TX        8'h1a
`define SPR_OFF_STAT      8'h20
`define SPR_RST_CTRL      8'h00
`define SPR_RST_THRESH    8'h0c
`define SPR_RST_PEAK      8'h00
`define SPR_RST_PAT       8'h00
`define SPR_RST_TX        8'h70
`define SPR_MASK_CTRL     8'hfe
`define SPR_MASK_TX       8'hfe
`define SPR_BIT_RECDIS    6
`define SPR_BIT_RECOG     5
`define SPR_BIT_SZHI      4
`define SPR_BIT_SZLO      3
`define SPR_BIT_TOLHI     2
`define SPR_BIT_TOLLO     1
`endif

// ---- rtl/spr_pkg.sv ----
// types for the start-pattern recognizer block
// assumes no surroundings; types only
package spr_pkg;
    typedef enum logic [1:0]
    {
        SPR_ST_IDLE  = 2'b01,
        SPR_ST_HUNT  = 2'b10
    } spr_state_t;
    typedef logic [7:0] spr_byte_t;
endpackage : spr_pkg

// ---- rtl/spr_apb_slave.sv ----
// apb slave decode for the config registers
// assumes an apb master on mclk; zero-wait answer
`timescale 1ns/100ps
`default_nettype none
`include "spr_consts.svh"
module spr_apb_slave
(
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst,
    // apb
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [31:0]  paddr,
    output logic              pready,
    output logic              pslverr,
    // decoded
    output logic              wrStb,
    output logic [7:0]        wrIdx,
    output logic              rdOk
);
    import spr_pkg::*;
    logic [7:0] idx;
    // word index; registers are byte addresses times one word
    assign idx     = paddr[9:2];
    assign pready  = 1'b1;
    assign rdOk    = (paddr[31:10] == 22'h00_0000) && (paddr[1:0] == 2'b00);
    // unmapped addresses error out instead of silently aliasing
    assign pslverr = psel && penable && !(rdOk && ((idx >= `SPR_OFF_CTRL && idx <= `SPR_OFF_TX)
                     || idx == `SPR_OFF_STAT));
    assign wrStb   = psel && penable && pwrite && !pslverr;
    assign wrIdx   = idx;
endmodule : spr_apb_slave
`default_nettype wire

// ---- rtl/spr_match.sv ----
// mismatch counter over the 32-bit window
// assumes masked pattern and history from the same clock
`timescale 1ns/100ps
`default_nettype none
module spr_match
(
    // inputs
    input  wire logic [31:0]  hist,
    input  wire logic [31:0]  pat,
    input  wire logic [31:0]  care,
    // result
    output logic [5:0]        errCnt
);
    logic [31:0] diff;
    assign diff = (hist ^ pat) & care;
    always_comb
    begin
        errCnt = 6'h00;
        for (int i = 0; i < 32; i++)
        begin
            errCnt = errCnt + {5'b0_0000, diff[i]};
        end
    end
endmodule : spr_match
`default_nettype wire

// ---- bench/spr_top_checker.sv ----
// concurrent checks on the recognizer top ports
// assumes one clock mclk and synchronous active-high rst
`timescale 1ns/100ps
`default_nettype none
module spr_top_checker
(
    // clock and reset
    input wire logic               mclk,
    input wire logic               rst,
    // apb
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [31:0]        paddr,
    input wire logic [31:0]        pwdata,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    // strength and config
    input wire spr_pkg::spr_byte_t rssiIn,
    input wire logic               recoveryEnable,
    input wire spr_pkg::spr_byte_t onoffThreshold,
    input wire logic [2:0]         peakDecayStep,
    input wire logic [2:0]         peakUpdateRate,
    input wire logic [1:0]         averageFilterSelect,
    input wire logic [3:0]         transmitFilterIndex,
    input wire logic [2:0]         outputPower,
    input wire logic               patternFound
);
    import spr_pkg::*;
    logic acc, wrAcc, rdAcc, recogReg, recogNext;
    assign acc   = psel && penable;
    assign wrAcc = acc && pwrite;
    assign rdAcc = acc && !pwrite;
    // shadow of the enable bit, a control field not on a port
    always_comb recogNext = (wrAcc && paddr == 32'h0000_0048) ? pwdata[5] : recogReg;
    always_ff @(posedge mclk) recogReg <= rst ? 1'b0 : recogNext;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    recovery_bit_a:
        assert property (wrAcc && paddr == 32'h0000_0048 |=> recoveryEnable == !$past(pwdata[6]))
        else $error("recovery enable wrong");
    recog_off_a:
        assert property (!recogReg |=> !patternFound) else $error("match while disabled");
    threshold_write_a:
        assert property (wrAcc && paddr == 32'h0000_004c |=> onoffThreshold == $past(pwdata[7:0]))
        else $error("threshold not stored");
    peak_fields_a:
        assert property (wrAcc && paddr == 32'h0000_0054 |=>
            {peakDecayStep, peakUpdateRate, averageFilterSelect} == $past(pwdata[7:0]))
        else $error("peak fields wrong");
    tx_fields_a:
        assert property (wrAcc && paddr == 32'h0000_0068 |=>
            {transmitFilterIndex, outputPower} == $past(pwdata[7:1])) else $error("tx fields wrong");
    config_hold_a:
        assert property (!wrAcc |=> $stable(onoffThreshold) && $stable(outputPower))
        else $error("config moved without write");
    strength_read_a:
        assert property (rdAcc && paddr == 32'h0000_0050 && !$past(rst) |->
            prdata[7:0] == $past(rssiIn) && prdata[31:8] == 24'h00_0000) else $error("strength read");
    strength_ro_a:
        assert property (wrAcc && paddr == 32'h0000_0050 |-> pready && !pslverr)
        else $error("strength write refused");
    unused_zero_a:
        assert property (rdAcc && (paddr == 32'h0000_0048 || paddr == 32'h0000_0068) |-> !prdata[0])
        else $error("unused bit set");
    misaligned_err_a:
        assert property (acc && paddr[1:0] != 2'b00 |-> pslverr && prdata == 32'h0000_0000)
        else $error("misaligned accepted");
endmodule : spr_top_checker
bind spr_top spr_top_checker u_chk (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rssiIn, .recoveryEnable, .onoffThreshold, .peakDecayStep,
    .peakUpdateRate, .averageFilterSelect, .transmitFilterIndex, .outputPower, .patternFound);
`default_nettype wire

// ---- bench/spr_bit_source.sv ----
// serial bit source standing in for the demodulator
// assumes the recognizer clock; one bit every second cycle
`timescale 1ns/100ps
`default_nettype none
module spr_bit_source
(
    // clock and control
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        start,
    input  wire logic [31:0] word,
    input  wire logic [5:0]  count,
    // serial out
    output logic             bitOut,
    output logic             bitValid,
    output logic             busy
);
    logic [31:0] shReg;
    logic [5:0]  leftReg;
    always_ff @(posedge mclk)
    begin
        bitValid <= 1'b0;
        // idle line toggles so no stale bit looks valid
        bitOut   <= ~bitOut;
        if (rst)
        begin
            busy   <= 1'b0;
            bitOut <= 1'b0;
        end
        else if (start && !busy)
        begin
            shReg   <= word << (6'd32 - count);
            leftReg <= count;
            busy    <= 1'b1;
        end
        else if (busy && !bitValid && leftReg != 6'd0)
        begin
            bitOut   <= shReg[31];
            bitValid <= 1'b1;
            shReg    <= shReg << 1;
            leftReg  <= leftReg - 6'd1;
        end
        else if (!bitValid)
            busy <= 1'b0;
    end
endmodule : spr_bit_source
`default_nettype wire

// ---- bench/spr_top_test.sv ----
// self-checking bench for the recognizer and its config registers
// assumes spr_top, its checker and the bit source are compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin testsRun++; if ((g) !== (e)) begin failCount++; \
    $display("BAD %0t got %h want %h", $time, (g), (e)); end end
module spr_top_test;
    import spr_pkg::*;
    logic        mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, prdata, rdat;
    logic        pready, pslverr, perr, recoveryEnable, polyphaseEnable, patternFound;
    spr_byte_t   rssiIn = 8'h00, onoffThreshold;
    logic [2:0]  peakDecayStep, peakUpdateRate, outputPower;
    logic [1:0]  averageFilterSelect;
    logic [3:0]  transmitFilterIndex;
    logic        srcStart = 1'b0, srcBit, srcValid, srcBusy, rawSel = 1'b0, seen = 1'b0;
    logic [31:0] srcWord = 32'h0000_0000;
    logic [5:0]  srcCnt = 6'h08;
    wire logic   rxRaw = rawSel ? srcBit : ~srcBit;
    wire logic   rxRawValid = rawSel & srcValid;
    wire logic   rxBit = rawSel ? ~srcBit : srcBit;
    wire logic   rxBitValid = ~rawSel & srcValid;
    int          failCount = 0, testsRun = 0, cyc = 0, seed = 98366;
    logic [7:0]  rstv [9] = '{8'h00, 8'h0c, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h70};
    logic [7:0]  v, p [4];
    always #12.5 mclk = ~mclk;
    spr_top uut (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .rxRaw, .rxRawValid, .rxBit, .rxBitValid, .rssiIn, .recoveryEnable,
        .polyphaseEnable, .onoffThreshold, .peakDecayStep, .peakUpdateRate,
        .averageFilterSelect, .transmitFilterIndex, .outputPower, .patternFound);
    spr_bit_source src (.mclk, .rst, .start(srcStart), .word(srcWord), .count(srcCnt),
        .bitOut(srcBit), .bitValid(srcValid), .busy(srcBusy));
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (patternFound === 1'b1)
            seen <= 1'b1;
        if (cyc == 10000)
        begin
            failCount++;
            close_out();
        end
    end
    function automatic logic [7:0] keep(input logic [7:0] i, input logic [7:0] d);
        return (i == 8'h12 || i == 8'h1a) ? (d & 8'hfe) : d;
    endfunction : keep
    function automatic logic hit(input int k, input logic [1:0] tol, input logic on);
        return on && (k <= int'(tol));
    endfunction : hit
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
            @(posedge mclk);
        while (pready !== 1'b1);
        rdat = prdata;
        perr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        apb(1'b1, {22'h00_0000, i, 2'b00}, {24'h00_0000, d});
    endtask : wr
    task automatic rd(input logic [7:0] i, input logic [7:0] e);
        apb(1'b0, {22'h00_0000, i, 2'b00}, 32'h0000_0000);
        `CHK({perr, rdat}, {1'b0, 24'h00_0000, e})
    endtask : rd
    task automatic close_out();
        $display("checks %0d mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    initial
    begin
        int k, nb, sz;
        logic [31:0] word, fl;
        logic [1:0] tol, md;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        for (int i = 0; i < 9; i++)
            rd(8'h12 + 8'(i), rstv[i]);
        repeat (6)
            for (int i = 0; i < 9; i++)
            begin
                v = 8'($random(seed));
                if (i == 2)
                    rssiIn <= v;
                wr(8'h12 + 8'(i), i == 2 ? ~v : v);
                rd(8'h12 + 8'(i), keep(8'h12 + 8'(i), v));
            end
        `CHK({transmitFilterIndex, outputPower}, v[7:1])
        apb(1'b0, 32'h0000_0044, 32'h0000_0000);
        `CHK({perr, rdat}, {1'b1, 32'h0000_0000})
        apb(1'b1, 32'h0000_004d, 32'h0000_00ff);
        `CHK(perr, 1'b1)
        // modes: flips at tolerance, one flip too many, raw path, recognition off
        for (int n = 0; n < 24; n++)
        begin
            md = 2'(n);
            for (int i = 0; i < 4; i++)
            begin
                p[i] = 8'($random(seed));
                wr(8'h16 + 8'(i), p[i]);
            end
            v = 8'($random(seed));
            sz = int'(v[1:0]);
            tol = v[3:2];
            nb = 8 * (sz + 1);
            k = int'(tol) + int'(md == 2'd1);
            fl = ((32'h0000_0001 << k) - 1) << ($unsigned($random(seed)) % (nb - k + 1));
            word = ({p[0], p[1], p[2], p[3]} >> (8 * (3 - sz))) ^ fl;
            wr(8'h12, 8'h00);
            wr(8'h20, 8'h01);
            rawSel <= (md == 2'd2);
            wr(8'h12, {v[4], md == 2'd2, md != 2'd3, 2'(sz), tol, 1'b0});
            `CHK({polyphaseEnable, recoveryEnable}, {v[4], md != 2'd2})
            seen <= 1'b0;
            srcWord <= word;
            srcCnt <= 6'(nb);
            srcStart <= 1'b1;
            @(posedge mclk);
            srcStart <= 1'b0;
            @(posedge mclk);
            while (srcBusy !== 1'b0)
                @(posedge mclk);
            repeat (3) @(posedge mclk);
            `CHK(seen, hit(k, tol, md != 2'd3))
            rd(8'h20, {7'h00, hit(k, tol, md != 2'd3)});
        end
        close_out();
    end
endmodule : spr_top_test
`default_nettype wire
